// >>> src/pop_defs.svh
// constants for the port-output / or / power-off decode slice
`ifndef POP_DEFS_SVH
`define POP_DEFS_SVH
`define POP_OPC_OR        10'h019
`define POP_OPC_POWER_OFF 10'h002
`define POP_OPC_PORT_ONE  10'h223
`define POP_OPC_PORT_TWO  10'h24a
`define POP_PORT_ONE_RST  4'h0
`define POP_PORT_TWO_RST  2'h0
`define POP_ACC_RST       4'h0
`define POP_X_W           2
`define POP_Y_W           4
`define POP_Z_W           1
`endif

// >>> src/pop_pkg.sv
// types for the port-output / or / power-off decode slice
package pop_pkg;
   typedef enum logic [2:0] {
      POP_OP_NONE,
      POP_OP_PORT_ONE,
      POP_OP_PORT_TWO,
      POP_OP_OR,
      POP_OP_POWER_OFF
   } pop_op_t;
   // data pointer: bank x, row y, column z
   typedef struct packed {
      logic [1:0] x;
      logic [3:0] y;
      logic       z;
   } pop_dp_t;
endpackage

// >>> src/pop_decoder.sv
// combinational decoder of the four handled instruction words
`timescale 1ns/1ns
`include "pop_defs.svh"
module pop_decoder (
   input  wire logic [9:0]     instr,
   input  wire logic           instr_valid,
   output pop_pkg::pop_op_t    op
);
   // one word per instruction, all others fall to none
   always_comb begin
      op = pop_pkg::POP_OP_NONE;
      if (instr_valid) begin
         unique case (instr)
            `POP_OPC_PORT_ONE:  op = pop_pkg::POP_OP_PORT_ONE;
            `POP_OPC_PORT_TWO:  op = pop_pkg::POP_OP_PORT_TWO;
            `POP_OPC_OR:        op = pop_pkg::POP_OP_OR;
            `POP_OPC_POWER_OFF: op = pop_pkg::POP_OP_POWER_OFF;
            default:            op = pop_pkg::POP_OP_NONE;
         endcase
      end
   end
endmodule

// >>> src/pop_exec.sv
// execute slice: port outputs, or with memory, power-off
`timescale 1ns/1ns
`include "pop_defs.svh"
module pop_exec (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [9:0]       instr,
   input  wire logic             instr_valid,
   input  wire logic             power_enable_prev,
   input  wire logic [3:0]       acc_in,
   input  wire pop_pkg::pop_dp_t data_pointer,
   input  wire logic [3:0]       pointed_memory_nibble,
   input  wire logic             wake,
   output logic [6:0]            mem_addr,
   output logic [3:0]            acc_out,
   output logic                  acc_we,
   output logic [3:0]            output_port_one,
   output logic [1:0]            output_port_two,
   output logic                  ram_backup,
   output logic                  carry_we,
   output logic                  skip
);
   pop_pkg::pop_op_t op;
   logic [3:0]       port_one_reg;
   logic [1:0]       port_two_reg;
   logic             backup_reg;
   logic [3:0]       acc_reg;
   logic             acc_we_reg;

   pop_decoder pop_decoder_i (
      .instr       (instr),
      .instr_valid (instr_valid),
      .op          (op)
   );

   // address from the pointer fields, bank above row above column
   function automatic logic [6:0] dp_addr(input pop_pkg::pop_dp_t dp);
      dp_addr = {dp.x, dp.y, dp.z};
   endfunction

   // one raw-word match, shared by the shadow latches and the decode checks
   function automatic logic word_hit(input logic       v,
                                     input logic [9:0] w,
                                     input logic [9:0] code);
      word_hit = v && (w == code);
   endfunction

   assign mem_addr = dp_addr(data_pointer);

   // none of these touch carry nor skip
   assign carry_we = 1'b0;
   assign skip     = 1'b0;

   // port one latch, holds between writes
   always_ff @(posedge clk) begin
      if (reset)
         port_one_reg <= `POP_PORT_ONE_RST;
      else if (op == pop_pkg::POP_OP_PORT_ONE)
         port_one_reg <= acc_in;
   end

   // port two latch, upper acc bits dropped
   always_ff @(posedge clk) begin
      if (reset)
         port_two_reg <= `POP_PORT_TWO_RST;
      else if (op == pop_pkg::POP_OP_PORT_TWO)
         port_two_reg <= acc_in[1:0];
   end

   // or result registered so acc writes back in the cycle after the or
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_reg    <= `POP_ACC_RST;
         acc_we_reg <= 1'b0;
      end else begin
         acc_we_reg <= (op == pop_pkg::POP_OP_OR);
         if (op == pop_pkg::POP_OP_OR)
            acc_reg <= acc_in | pointed_memory_nibble;
      end
   end

   // back-up state; wake is the core's business, only cleared here
   always_ff @(posedge clk) begin
      if (reset)
         backup_reg <= 1'b0;
      else if (op == pop_pkg::POP_OP_POWER_OFF && power_enable_prev)
         backup_reg <= 1'b1;
      else if (wake)
         backup_reg <= 1'b0;
   end

   assign output_port_one = port_one_reg;
   assign output_port_two = port_two_reg;
   assign acc_out         = acc_reg;
   assign acc_we          = acc_we_reg;
   assign ram_backup      = backup_reg;

   // shadow copies rebuilt from the raw word, independent of the decoder,
   // so the latch checks still bite if the decode table goes wrong
   logic [3:0] shadow_one_reg;
   logic [1:0] shadow_two_reg;
   logic       shadow_backup_reg;

   // shadow port latches
   always_ff @(posedge clk) begin
      if (reset) begin
         shadow_one_reg <= `POP_PORT_ONE_RST;
         shadow_two_reg <= `POP_PORT_TWO_RST;
      end else begin
         if (word_hit(instr_valid, instr, `POP_OPC_PORT_ONE))
            shadow_one_reg <= acc_in;
         if (word_hit(instr_valid, instr, `POP_OPC_PORT_TWO))
            shadow_two_reg <= acc_in[1:0];
      end
   end

   // shadow back-up flag, entry beats wake like the real one
   always_ff @(posedge clk) begin
      if (reset)
         shadow_backup_reg <= 1'b0;
      else if (word_hit(instr_valid, instr, `POP_OPC_POWER_OFF) &&
               power_enable_prev)
         shadow_backup_reg <= 1'b1;
      else if (wake)
         shadow_backup_reg <= 1'b0;
   end

   // every check samples on the rising edge and sleeps while in reset
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // decode: each handled word maps to its own operation
   chk_decode_port_one: assert property (
      word_hit(instr_valid, instr, `POP_OPC_PORT_ONE)
      |-> op == pop_pkg::POP_OP_PORT_ONE)
      else $error("port one word not decoded");
   chk_decode_port_two: assert property (
      word_hit(instr_valid, instr, `POP_OPC_PORT_TWO)
      |-> op == pop_pkg::POP_OP_PORT_TWO)
      else $error("port two word not decoded");
   chk_decode_or: assert property (
      word_hit(instr_valid, instr, `POP_OPC_OR)
      |-> op == pop_pkg::POP_OP_OR)
      else $error("or word not decoded");
   chk_decode_pof: assert property (
      word_hit(instr_valid, instr, `POP_OPC_POWER_OFF)
      |-> op == pop_pkg::POP_OP_POWER_OFF)
      else $error("power-off word not decoded");
   // a word without valid is no instruction at all
   chk_invalid_idle: assert property (
      !instr_valid |-> op == pop_pkg::POP_OP_NONE)
      else $error("operation decoded without valid");

   // port latches: load at cycle end from the accumulator

   chk_port_one_copy: assert property (
      op == pop_pkg::POP_OP_PORT_ONE |=> output_port_one == $past(acc_in))
      else $error("port one not loaded from acc");
   chk_port_two_copy: assert property (
      op == pop_pkg::POP_OP_PORT_TWO |=> output_port_two == $past(acc_in[1:0]))
      else $error("port two not loaded from acc low bits");
   // an output to one port leaves the other port alone
   chk_port_one_alone: assert property (
      op == pop_pkg::POP_OP_PORT_TWO |=> $stable(output_port_one))
      else $error("port one moved on port two output");
   chk_port_two_alone: assert property (
      op == pop_pkg::POP_OP_PORT_ONE |=> $stable(output_port_two))
      else $error("port two moved on port one output");

   // or result and its write-back pulse
   chk_or_result: assert property (
      op == pop_pkg::POP_OP_OR |=>
         acc_we && acc_out == ($past(acc_in) | $past(pointed_memory_nibble)))
      else $error("or result wrong");
   // write enable is high only in the cycle after an or
   chk_acc_we_pulse: assert property (
      op != pop_pkg::POP_OP_OR |=> !acc_we)
      else $error("acc write without or");
   // or result stays put between or instructions
   chk_acc_hold: assert property (
      op != pop_pkg::POP_OP_OR |=> $stable(acc_out))
      else $error("acc result changed without or");

   // back-up entry only with the enabling instruction just before
   chk_backup_entry: assert property (
      op == pop_pkg::POP_OP_POWER_OFF && power_enable_prev |=> ram_backup)
      else $error("power-off did not enter back-up");
   chk_poweroff_nop: assert property (
      op == pop_pkg::POP_OP_POWER_OFF && !power_enable_prev && !ram_backup
      |=> !ram_backup)
      else $error("power-off acted without enable");
   // enable alone, without the power-off word, changes nothing
   chk_enable_alone: assert property (
      power_enable_prev && op != pop_pkg::POP_OP_POWER_OFF && !ram_backup
      |=> !ram_backup)
      else $error("back-up entered without power-off");
   // once in back-up, only wake or reset brings it out
   chk_backup_hold: assert property (
      ram_backup && !wake |=> ram_backup)
      else $error("back-up dropped without wake");
   // wake clears back-up unless an entry lands in the same cycle
   chk_wake_clear: assert property (
      wake && !(op == pop_pkg::POP_OP_POWER_OFF && power_enable_prev)
      |=> !ram_backup)
      else $error("wake did not leave back-up");
   // power-off never reaches into the port latches or the accumulator
   chk_pof_quiet: assert property (
      op == pop_pkg::POP_OP_POWER_OFF
      |=> $stable(output_port_one) && $stable(output_port_two) && !acc_we)
      else $error("power-off disturbed ports or acc");

   // pointer to address, same cycle; ports hold without an output; carry and skip stay low
   chk_mem_addr: assert property (
      mem_addr == {data_pointer.x, data_pointer.y, data_pointer.z})
      else $error("memory address not from data pointer");
   chk_port_hold: assert property (
      op != pop_pkg::POP_OP_PORT_ONE && op != pop_pkg::POP_OP_PORT_TWO
      |=> $stable(output_port_one) && $stable(output_port_two))
      else $error("port latch changed without output");
   chk_no_carry: assert property (
      carry_we == 1'b0 && skip == 1'b0)
      else $error("carry or skip disturbed");

   // outputs against the decoder-free shadow copies
   chk_port_shadow: assert property (
      output_port_one == shadow_one_reg && output_port_two == shadow_two_reg)
      else $error("port latch differs from raw-word shadow");
   chk_backup_shadow: assert property (
      ram_backup == shadow_backup_reg)
      else $error("back-up differs from raw-word shadow");

   // main scenarios worth seeing at least once

   cov_port_one: cover property (op == pop_pkg::POP_OP_PORT_ONE);
   cov_port_two: cover property (op == pop_pkg::POP_OP_PORT_TWO);
   cov_or:       cover property (op == pop_pkg::POP_OP_OR);
   cov_pof_ok:   cover property (
      op == pop_pkg::POP_OP_POWER_OFF && power_enable_prev);
   cov_pof_nop:  cover property (
      op == pop_pkg::POP_OP_POWER_OFF && !power_enable_prev);
endmodule

// >>> tb/pop_exec_tb.sv
// self-checking bench for the port-output / or / power-off slice
`timescale 1ns/1ns
module pop_exec_tb;
   logic             clk = 1'b0;
   logic             reset = 1'b1;
   logic [9:0]       instr = 10'h000;
   logic             instr_valid = 1'b0;
   logic             power_enable_prev = 1'b0;
   logic [3:0]       acc_in = 4'h0;
   pop_pkg::pop_dp_t data_pointer = '0;
   logic [3:0]       pointed_memory_nibble = 4'h0;
   logic             wake = 1'b0;
   logic [6:0]       mem_addr;
   logic [3:0]       acc_out;
   logic             acc_we;
   logic [3:0]       output_port_one;
   logic [1:0]       output_port_two;
   logic             ram_backup;
   logic             carry_we;
   logic             skip;
   int               n_fail = 0;
   int               n_checks = 0;

   always #5 clk = ~clk;

   pop_exec pop_exec_i (.clk(clk), .reset(reset), .instr(instr),
      .instr_valid(instr_valid), .power_enable_prev(power_enable_prev),
      .acc_in(acc_in), .data_pointer(data_pointer),
      .pointed_memory_nibble(pointed_memory_nibble), .wake(wake),
      .mem_addr(mem_addr), .acc_out(acc_out), .acc_we(acc_we),
      .output_port_one(output_port_one), .output_port_two(output_port_two),
      .ram_backup(ram_backup), .carry_we(carry_we), .skip(skip));

   // widest result is the 7-bit address; narrower ones zero-extend
   task cmp(input logic [6:0] got, input logic [6:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // valid follows v and holds until the next call, so each call drives one cycle
   task issue(input logic [9:0] w, input logic [3:0] a, input logic v);
      instr = w;
      acc_in = a;
      instr_valid = v;
      @(posedge clk);
      #1;
   endtask

   task end_sim;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task t_ports;
      issue(10'h223, 4'h5, 1'b1);
      cmp(7'(output_port_one), 7'h05);
      issue(10'h24a, 4'he, 1'b1);
      cmp(7'(output_port_two), 7'h02);
      cmp(7'(output_port_one), 7'h05);
      cmp(7'({carry_we, skip}), 7'h00);
      issue(10'h223, 4'ha, 1'b0);
      cmp(7'(output_port_one), 7'h05);
      issue(10'h223, 4'h9, 1'b1);
      cmp(7'({output_port_one, output_port_two}), 7'h26);
   endtask

   task t_or;
      data_pointer = '{x: 2'h2, y: 4'h9, z: 1'b1};
      pointed_memory_nibble = 4'h4;
      issue(10'h019, 4'h9, 1'b1);
      cmp(mem_addr, 7'h53);
      cmp(7'({acc_we, acc_out}), 7'h1d);
      issue(10'h019, 4'h2, 1'b1);
      cmp(7'({acc_we, acc_out}), 7'h16);
      issue(10'h019, 4'h9, 1'b0);
      cmp(7'(acc_we), 7'h00);
   endtask

   task t_pof;
      issue(10'h002, 4'h0, 1'b1);
      cmp(7'(ram_backup), 7'h00);
      power_enable_prev = 1'b1;
      issue(10'h000, 4'h0, 1'b1);
      cmp(7'(ram_backup), 7'h00);
      issue(10'h002, 4'h0, 1'b1);
      cmp(7'(ram_backup), 7'h01);
      power_enable_prev = 1'b0;
      issue(10'h000, 4'h0, 1'b0);
      cmp(7'(ram_backup), 7'h01);
      wake = 1'b1;
      issue(10'h000, 4'h0, 1'b0);
      cmp(7'(ram_backup), 7'h00);
      power_enable_prev = 1'b1;
      issue(10'h002, 4'h0, 1'b1);
      cmp(7'(ram_backup), 7'h01);
      wake = 1'b0;
      power_enable_prev = 1'b0;
   endtask

   // mid-run reset: a port write in the reset cycle must not land
   task t_reset;
      reset = 1'b1;
      issue(10'h223, 4'hf, 1'b1);
      cmp(7'({output_port_one, output_port_two, ram_backup}), 7'h00);
      reset = 1'b0;
      issue(10'h000, 4'h0, 1'b0);
      cmp(7'({acc_we, acc_out}), 7'h00);
   endtask

   // hang guard: far beyond the twenty cycles the run needs
   initial begin
      #100000;
      n_fail++;
      end_sim;
   end

   initial begin
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      cmp(7'({output_port_one, output_port_two}), 7'h00);
      cmp(7'({acc_we, acc_out, ram_backup}), 7'h00);
      t_ports;
      t_or;
      t_pof;
      t_reset;
      end_sim;
   end
endmodule
